// >>> vdram_port.sv
// Pin-level logic of a 64K x 1 dual-port video DRAM.
// Assumes a controller drives the strobes; all pins are
// asynchronous and pass two flip-flops before use.
`timescale 1ns/1ps
`default_nettype none

module vdram_port
   import vdram_pkg::*;
(
   input  wire logic             ref_clk_in,
   input  wire logic             srst_in,
   input  wire logic             row_strobe_n_in,
   input  wire logic             column_strobe_n_in,
   input  wire logic             store_select_n_in,
   input  wire logic             xfer_select_out_enable_n_in,
   input  wire logic [ROW_W-1:0] addr_bus_in,
   input  wire logic             input_bit_in,
   output logic                  output_bit_out,
   output logic                  output_bit_oe_out,
   input  wire logic             shift_clock_in,
   input  wire logic             serial_input_in,
   input  wire logic             serial_drive_enable_n_in,
   output logic                  serial_output_out,
   output logic                  serial_output_oe_out
);

   // =========================================================
   // Edge helpers on synchronised samples
   function automatic logic fell(input logic p, input logic c);
      return p & ~c;
   endfunction : fell

   function automatic logic rose(input logic p, input logic c);
      return ~p & c;
   endfunction : rose

   // =========================================================
   // State
   typedef struct packed {
      mode_t              mode;
      logic [IN_W-1:0]    prev;
      logic [ROW_W-1:0]   row;
      logic [COL_W-1:0]   col;
      logic               col_ok;
      logic               early;
      logic [SEC_W-1:0]   sec;
      logic               pend_ld;
      logic [SR_BITS-1:0] pend;
      logic               q;
      logic               q_oe;
      logic               so_oe;
   } port_st_t;

   port_st_t st_q;
   port_st_t st_d;

   logic [IN_W-1:0]    s;
   logic               ras_n;
   logic               cas_n;
   logic               we_n;
   logic               tr_n;
   logic [ROW_W-1:0]   addr;
   logic               ras_fall;
   logic               ras_rise;
   logic               cas_fall;
   logic               wr_bit_en;
   logic [COL_W-1:0]   wr_col;
   logic               wr_row_en;
   logic               ld;

   // Array kept as 256 rows of 256 bits; no reset, like the cells
   logic [SR_BITS-1:0] mem [0:(1<<ROW_W)-1];

   sr_link_if sr ();

   // =========================================================
   // Pin synchroniser
   pin_sync u_sync (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .pins_in    ({addr_bus_in,
                    serial_drive_enable_n_in,
                    serial_input_in,
                    shift_clock_in,
                    input_bit_in,
                    xfer_select_out_enable_n_in,
                    store_select_n_in,
                    column_strobe_n_in,
                    row_strobe_n_in}),
      .pins_out   (s)
   );

   // Named views of the sampled pins
   assign ras_n    = s[IN_RAS];
   assign cas_n    = s[IN_CAS];
   assign we_n     = s[IN_WE];
   assign tr_n     = s[IN_TR];
   assign addr     = s[IN_ADDR +: ROW_W];
   assign ras_fall = fell(st_q.prev[IN_RAS], ras_n);
   assign ras_rise = rose(st_q.prev[IN_RAS], ras_n);
   assign cas_fall = fell(st_q.prev[IN_CAS], cas_n);

   // =========================================================
   // Serial port
   // Shifting never waits on the random port; only a load
   // at the end of a transfer takes the chain over.
   assign sr.shift = rose(st_q.prev[IN_SCLK], s[IN_SCLK]);
   assign sr.serial_input   = s[IN_SIN];
   assign sr.load  = ld;
   // Start section drops the lower sections off the tap
   assign sr.load_data =
      st_q.pend >> {st_q.sec, 6'h00};

   serial_chain u_chain (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .sr         (sr.chain)
   );

   // =========================================================
   // Sequencer
   always_comb begin
      st_d      = st_q;
      st_d.prev = s;
      wr_bit_en = 1'b0;
      wr_col    = addr;
      wr_row_en = 1'b0;
      ld        = 1'b0;
      st_d.so_oe = ~s[IN_SOE];

      // Row strobe opens a cycle and fixes its kind
      if (ras_fall) begin
         st_d.row    = addr;
         st_d.col_ok = 1'b0;
         st_d.early  = 1'b0;
         if (tr_n) begin
            st_d.mode = MODE_ACCESS;
         end else begin
            st_d.mode = MODE_XFER;
            if (!we_n) begin
               wr_row_en = 1'b1;
            end else begin
               // Sensing the row also restores it
               st_d.pend    = mem[addr];
               st_d.pend_ld = 1'b1;
            end
         end
      end else if (ras_rise) begin
         st_d.mode    = MODE_IDLE;
         st_d.col_ok  = 1'b0;
         st_d.early   = 1'b0;
         ld           = st_q.pend_ld;
         st_d.pend_ld = 1'b0;
      end

      // Each column strobe under an open access row is served
      if (st_q.mode == MODE_ACCESS && cas_fall) begin
         st_d.col    = addr;
         st_d.col_ok = 1'b1;
         if (!we_n) begin
            st_d.early = 1'b1;
            wr_bit_en  = 1'b1;
         end else begin
            st_d.q = mem[st_q.row][addr];
         end
      end

      // Section code only matters for array-to-register loads
      if (st_q.mode == MODE_XFER && cas_fall) begin
         st_d.sec = addr[SEC_LSB +: SEC_W];
      end

      // Write falls after the column strobe: delayed write
      if (st_q.mode == MODE_ACCESS && st_q.col_ok && !cas_n
          && !st_q.early && fell(st_q.prev[IN_WE], we_n)) begin
         wr_bit_en = 1'b1;
         wr_col    = st_q.col;
      end

      if (rose(st_q.prev[IN_CAS], cas_n)) begin
         st_d.col_ok = 1'b0;
         st_d.early  = 1'b0;
      end

      // Output drives only in a read or delayed write with both enables low
      st_d.q_oe = st_d.mode == MODE_ACCESS && st_d.col_ok
                  && !st_d.early && !cas_n && !tr_n;
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         st_q         <= '0;
         st_q.mode    <= MODE_IDLE;
         st_q.prev    <= IN_RST;
         st_q.sec     <= SEC_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // =========================================================
   // Array writes
   // A row store and a bit write never share a clock: one
   // needs a row fall in transfer, the other an open access.
   always_ff @(posedge ref_clk_in) begin
      if (wr_row_en) begin
         mem[addr] <= sr.bits;
      end
      if (wr_bit_en) begin
         mem[st_q.row][wr_col] <= s[IN_DIN];
      end
   end

   // =========================================================
   // Outputs, all from flip-flops
   assign output_bit_out       = st_q.q;
   assign output_bit_oe_out    = st_q.q_oe;
   assign serial_output_out    = sr.serial_output;
   assign serial_output_oe_out = st_q.so_oe;

   // =========================================================
   // Checks
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (srst_in);

   access_select_a: assert property (
      ras_fall && tr_n |=> st_q.mode == MODE_ACCESS)
      else $error("row fall with enable high missed access");

   xfer_select_a: assert property (
      ras_fall && !tr_n |=> st_q.mode == MODE_XFER
         && !output_bit_oe_out)
      else $error("row fall with enable low missed transfer");

   xfer_float_a: assert property (
      st_q.mode == MODE_XFER |-> !output_bit_oe_out)
      else $error("data out driven in transfer");

   q_enable_cause_a: assert property (
      output_bit_oe_out |-> $past(!cas_n) && $past(!tr_n)
         && st_q.col_ok)
      else $error("data out driven without both enables");

   enable_high_float_a: assert property (
      tr_n ##1 tr_n |=> !output_bit_oe_out)
      else $error("data out driven while enable high");

   early_float_a: assert property (
      st_q.early |-> !output_bit_oe_out)
      else $error("data out driven in early write");

   bit_write_a: assert property (
      wr_bit_en |=> mem[$past(st_q.row)][$past(wr_col)]
         == $past(s[IN_DIN]))
      else $error("bit write did not land");

   read_data_a: assert property (
      st_q.mode == MODE_ACCESS && cas_fall && we_n
         |=> output_bit_out == $past(mem[st_q.row][addr]))
      else $error("read data wrong");

   section_hold_a: assert property (
      !(st_q.mode == MODE_XFER && cas_fall) |=> $stable(st_q.sec))
      else $error("section code changed without column fall");

   load_at_rise_a: assert property (
      ras_rise && st_q.pend_ld |-> sr.load ##1 !st_q.pend_ld)
      else $error("register not loaded at row rise");

   serial_float_a: assert property (
      s[IN_SOE] |=> !serial_output_oe_out)
      else $error("serial output driven while disabled");

   // =========================================================
   // Latches, array store and the serial tap
   row_latch_a: assert property (
      ras_fall |=> st_q.row == $past(addr))
      else $error("row address not latched at row fall");

   col_latch_a: assert property (
      st_q.mode == MODE_ACCESS && cas_fall |=> st_q.col == $past(addr)
         && st_q.mode == MODE_ACCESS)
      else $error("column not served under the open row");

   // The store must land even while the chain keeps shifting
   store_row_a: assert property (
      wr_row_en |=> mem[$past(addr)] == $past(sr.bits))
      else $error("register not stored into the row");

   // The first bit out must be bit 0 of the chosen section
   start_bit_a: assert property (
      sr.load |=> sr.serial_output == $past(st_q.pend[{st_q.sec, 6'h00}]))
      else $error("serial output not at start of section");

   // A load in an access cycle would break serial shifting
   xfer_only_load_a: assert property (
      sr.load |-> st_q.mode == MODE_XFER)
      else $error("register loaded outside a transfer");

   serial_drive_a: assert property (
      !s[IN_SOE] |=> serial_output_oe_out)
      else $error("serial output not driven while enabled");

   cover_read_c: cover property (
      st_q.mode == MODE_ACCESS ##1 output_bit_oe_out);
   cover_page_c: cover property (
      st_q.mode == MODE_ACCESS && cas_fall ##[1:40]
      st_q.mode == MODE_ACCESS && cas_fall);
   cover_load_c: cover property (sr.load);
   cover_store_c: cover property (wr_row_en);
   cover_delayed_c: cover property (
      st_q.col_ok && !st_q.early && wr_bit_en);

endmodule : vdram_port

`default_nettype wire

// >>> vdram_pkg.sv
// Shared constants and types for the video DRAM port logic.
// Assumes a single 50 MHz clock samples every device pin.
`default_nettype none

package vdram_pkg;

   // =========================================================
   // Array and shift register geometry
   localparam int ROW_W    = 8;
   localparam int COL_W    = 8;
   localparam int SR_BITS  = 256;
   localparam int SEC_W    = 2;
   localparam int SEC_LSB  = 6;

   // =========================================================
   // Bit positions inside the synchronised pin vector
   localparam int IN_RAS   = 0;
   localparam int IN_CAS   = 1;
   localparam int IN_WE    = 2;
   localparam int IN_TR    = 3;
   localparam int IN_DIN   = 4;
   localparam int IN_SCLK  = 5;
   localparam int IN_SIN   = 6;
   localparam int IN_SOE   = 7;
   localparam int IN_ADDR  = 8;
   localparam int IN_W     = 16;

   // Idle pin levels: strobes, write, transfer, serial enable high
   localparam logic [IN_W-1:0]  IN_RST  = 16'h008f;
   localparam logic [SEC_W-1:0] SEC_RST = 2'h0;

   // =========================================================
   // Cycle kinds opened by the row strobe
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_ACCESS,
      MODE_XFER
   } mode_t;

endpackage : vdram_pkg

`default_nettype wire

// >>> sr_link_if.sv
// Link between the port sequencer and the serial shift chain.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface sr_link_if;
   import vdram_pkg::*;

   logic               shift;
   logic               serial_input;
   logic               load;
   logic [SR_BITS-1:0] load_data;
   logic [SR_BITS-1:0] bits;
   logic               serial_output;

   // Sequencer side
   modport ctrl  (output shift, serial_input, load, load_data,
                  input  bits, serial_output);
   // Shift chain side
   modport chain (input  shift, serial_input, load, load_data,
                  output bits, serial_output);

endinterface : sr_link_if

`default_nettype wire

// >>> pin_sync.sv
// Two-stage synchroniser for every asynchronous device pin.
// Assumes pins idle at the levels held in IN_RST.
`timescale 1ns/1ps
`default_nettype none

module pin_sync
   import vdram_pkg::*;
(
   input  wire logic            ref_clk_in,
   input  wire logic            srst_in,
   input  wire logic [IN_W-1:0] pins_in,
   output logic      [IN_W-1:0] pins_out
);

   typedef struct packed {
      logic [IN_W-1:0] s1;
      logic [IN_W-1:0] s2;
   } sync_st_t;

   sync_st_t st_q;
   sync_st_t st_d;

   // =========================================================
   // First stage feeds only the second stage
   always_comb begin
      st_d    = st_q;
      st_d.s1 = pins_in;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         st_q <= {IN_RST, IN_RST};
      end else begin
         st_q <= st_d;
      end
   end

   assign pins_out = st_q.s2;

endmodule : pin_sync

`default_nettype wire

// >>> serial_chain.sv
// The 256-element serial register with parallel load.
// Assumes load and shift pulses last one clock.
`timescale 1ns/1ps
`default_nettype none

module serial_chain
   import vdram_pkg::*;
(
   input  wire logic ref_clk_in,
   input  wire logic srst_in,
   sr_link_if.chain  sr
);

   typedef struct packed {
      logic [SR_BITS-1:0] bits;
   } chain_st_t;

   chain_st_t st_q;
   chain_st_t st_d;

   // =========================================================
   // Load wins over a shift in the same clock
   always_comb begin
      st_d = st_q;
      if (sr.load) begin
         st_d.bits = sr.load_data;
      end else if (sr.shift) begin
         st_d.bits = {sr.serial_input, st_q.bits[SR_BITS-1:1]};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sr.bits = st_q.bits;
   assign sr.serial_output = st_q.bits[0];

   // =========================================================
   // Checks
   shift_step_a: assert property (@(posedge ref_clk_in)
      disable iff (srst_in)
      sr.shift && !sr.load |=> sr.serial_output == $past(sr.bits[1])
         && sr.bits[SR_BITS-1] == $past(sr.serial_input))
      else $error("serial chain did not advance");

endmodule : serial_chain

`default_nettype wire

// >>> vdram_ctrl_model.sv
// Controller model that drives the video DRAM pins.
// Assumes the 50 MHz reference clock; pins move at its falling edge.
`timescale 1ns/1ps
`default_nettype none

module vdram_ctrl_model (
   input  wire logic       clk_in,
   input  wire logic       serial_output_in,
   output logic            row_n_out,
   output logic            col_n_out,
   output logic            we_n_out,
   output logic            tr_n_out,
   output logic [7:0]      addr_out,
   output logic            din_out,
   output logic            sclk_out,
   output logic            sin_out,
   output logic            soe_n_out
);
   // ==========================================================
   // Idle levels; address and data lines stay separate, so
   // early writes are legal here
   initial begin
      row_n_out = 1'b1;
      col_n_out = 1'b1;
      we_n_out  = 1'b1;
      tr_n_out  = 1'b1;
      addr_out  = 8'h00;
      din_out   = 1'b0;
      sclk_out  = 1'b0;
      sin_out   = 1'b0;
      soe_n_out = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(negedge clk_in);
   endtask : wt

   // ==========================================================
   // Strobe cycles; each level is held above the 3 clocks needed
   task automatic row_open(input logic [7:0] a, input logic tr,
                           input logic we);
      addr_out = a;
      tr_n_out = tr;
      we_n_out = we;
      wt(4);
      row_n_out = 1'b0;
      wt(4);
   endtask : row_open

   task automatic row_close();
      row_n_out = 1'b1;
      tr_n_out = 1'b1;
      addr_out = ~addr_out; // Released bus shows no old value
      wt(4);
   endtask : row_close

   // Many column strobes may follow one row fall
   task automatic col_fall(input logic [7:0] a, input logic tr,
                           input logic we, input logic d);
      addr_out = a;
      tr_n_out = tr;
      we_n_out = we;
      din_out = d;
      wt(4);
      col_n_out = 1'b0;
      wt(6);
   endtask : col_fall

   task automatic col_rise();
      col_n_out = 1'b1;
      we_n_out = 1'b1;
      tr_n_out = 1'b1;
      din_out = ~din_out;
      wt(4);
   endtask : col_rise

   // Store falls while the column strobe is already low
   task automatic we_fall(input logic d);
      din_out = d;
      wt(3);
      we_n_out = 1'b0;
      wt(4);
   endtask : we_fall

   task automatic en(input logic v);
      tr_n_out = v;
      wt(5);
   endtask : en

   task automatic serial_drive_enable(input logic v);
      soe_n_out = v;
      wt(4);
   endtask : serial_drive_enable

   // ==========================================================
   // Serial clock idles low between bursts; each level lasts
   // four reference clocks, a 160 ns serial period
   task automatic burst(input int n, input logic [255:0] s,
                        output logic [255:0] q);
      for (int i = 0; i < n; i++) begin
         sin_out = s[i];
         wt(4);
         q[i] = serial_output_in;
         sclk_out = 1'b1;
         wt(4);
         sclk_out = 1'b0;
      end
      sin_out = ~sin_out;
      wt(4);
   endtask : burst
endmodule : vdram_ctrl_model

`default_nettype wire

// >>> dual_port_video_dram_interface_bench.sv
// Self-checking bench for the video DRAM port logic.
// Assumes vdram_port and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module dual_port_video_dram_interface_bench;
   import vdram_pkg::*;

   logic         ref_clk_in;
   logic         srst_in;
   logic         row_n, col_n, we_n, tr_n, din, sclk, serial_input, soe_n;
   logic         dout, dout_oe, serial_output, serial_output_oe;
   logic [7:0]   addr;
   logic [255:0] rowv;
   logic [255:0] q;
   int           err_count = 0;
   int           total_checks = 0;
   int           cycles = 0;

   // ==========================================================
   // Controller model and unit
   vdram_ctrl_model ctl (
      .clk_in   (ref_clk_in),
      .serial_output_in  (serial_output),
      .row_n_out(row_n),
      .col_n_out(col_n),
      .we_n_out (we_n),
      .tr_n_out (tr_n),
      .addr_out (addr),
      .din_out  (din),
      .sclk_out (sclk),
      .sin_out  (serial_input),
      .soe_n_out(soe_n)
   );

   vdram_port uut (
      .ref_clk_in                 (ref_clk_in),
      .srst_in                    (srst_in),
      .row_strobe_n_in            (row_n),
      .column_strobe_n_in         (col_n),
      .store_select_n_in          (we_n),
      .xfer_select_out_enable_n_in(tr_n),
      .addr_bus_in                (addr),
      .input_bit_in               (din),
      .output_bit_out             (dout),
      .output_bit_oe_out          (dout_oe),
      .shift_clock_in             (sclk),
      .serial_input_in            (serial_input),
      .serial_drive_enable_n_in   (soe_n),
      .serial_output_out          (serial_output),
      .serial_output_oe_out       (serial_output_oe)
   );

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // Hang guard, well above the roughly 12k cycles expected
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count++;
         give_verdict();
      end
   end

   // ==========================================================
   // Comparison and closing report
   task automatic check(input string what, input logic [255:0] seen,
                        input logic [255:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      if (err_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   // Read with enable high first, data in opposite to the cell
   task automatic rd(input logic [7:0] r, input logic [7:0] c,
                     input logic e);
      ctl.row_open(r, 1'b1, 1'b1);
      ctl.col_fall(c, 1'b1, 1'b1, ~e);
      check("oe masked", dout_oe, 1'b0);
      ctl.en(1'b0);
      check("oe read", dout_oe, 1'b1);
      check("read data", dout, e);
      ctl.en(1'b1);
      check("oe dropped", dout_oe, 1'b0);
      ctl.en(1'b0);
      ctl.col_rise();
      check("oe after column", dout_oe, 1'b0);
      ctl.row_close();
   endtask : rd

   // ==========================================================
   // Scenarios
   task automatic t_rand();
      ctl.row_open(8'h5a, 1'b1, 1'b1);
      for (int c = 0; c < 256; c++) begin
         ctl.col_fall(8'(c), 1'b0, 1'b0, rowv[c]);
         check("oe early write", dout_oe, 1'b0);
         ctl.col_rise();
      end
      ctl.row_close();
      ctl.row_open(8'ha5, 1'b1, 1'b1);
      ctl.col_fall(8'h03, 1'b0, 1'b0, ~rowv[3]);
      ctl.col_rise();
      ctl.row_close();
      for (int c = 3; c < 256; c += 50) begin
         rd(8'h5a, 8'(c), rowv[c]);
      end
      rd(8'ha5, 8'h03, ~rowv[3]);
   endtask : t_rand

   // The cell is written early first, so the old data is known
   task automatic t_delayed();
      ctl.row_open(8'h33, 1'b1, 1'b1);
      ctl.col_fall(8'h0f, 1'b0, 1'b0, rowv[8'h0f]);
      check("oe early write", dout_oe, 1'b0);
      ctl.col_rise();
      ctl.col_fall(8'h0f, 1'b0, 1'b1, 1'b1);
      ctl.we_fall(1'b1);
      check("oe delayed write", dout_oe, 1'b1);
      check("old data", dout, rowv[8'h0f]);
      ctl.col_rise();
      ctl.row_close();
      rd(8'h33, 8'h0f, 1'b1);
   endtask : t_delayed

   // First serial data only after a transfer
   task automatic t_load();
      logic [255:0] m;
      for (int s = 0; s < 4; s++) begin
         ctl.row_open(8'h5a, 1'b0, 1'b1);
         ctl.col_fall({2'(s), 6'h15}, 1'b0, 1'b1, 1'b0);
         check("oe transfer", dout_oe, 1'b0);
         ctl.col_rise();
         ctl.row_close();
         ctl.burst(256 - 64 * s, '0, q);
         m = {256{1'b1}} >> (64 * s);
         check("loaded bits", q & m, (rowv >> (64 * s)) & m);
      end
      ctl.row_open(8'h5a, 1'b0, 1'b1);
      ctl.row_close();
      ctl.burst(64, '0, q);
      check("kept section", q[63:0], rowv[255:192]);
      ctl.serial_drive_enable(1'b1);
      check("serial oe off", serial_output_oe, 1'b0);
      ctl.serial_drive_enable(1'b0);
      check("serial oe on", serial_output_oe, 1'b1);
   endtask : t_load

   task automatic t_store();
      ctl.row_open(8'h81, 1'b1, 1'b1);
      check("oe refresh", dout_oe, 1'b0);
      ctl.row_close();
      fork
         ctl.burst(256, ~rowv, q);
         rd(8'h33, 8'h0f, 1'b1);
      join
      ctl.row_open(8'h77, 1'b0, 1'b0);
      ctl.row_close();
      for (int c = 0; c < 256; c += 51) begin
         rd(8'h77, 8'(c), ~rowv[c]);
      end
   endtask : t_store

   initial begin
      srst_in = 1'b1;
      for (int c = 0; c < 256; c++) begin
         rowv[c] = ^(8'(c) & 8'h29);
      end
      repeat (8) @(negedge ref_clk_in);
      srst_in = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      t_rand();
      t_delayed();
      t_load();
      t_store();
      give_verdict();
   end
endmodule : dual_port_video_dram_interface_bench

`default_nettype wire
